// ### design/reference_delay_align.sv
`timescale 1ns/100ps

// ----------------------------------------
// aligned pair buffer
// ----------------------------------------
module pair_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } fifo_state_t;

    fifo_state_t f_reg;
    fifo_state_t f_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // handshakes on both sides
    assign inReady = (f_reg.cnt != CW'(DEPTH));
    assign outValid = (f_reg.cnt != '0);
    assign outData = mem[f_reg.rp];
    assign count = f_reg.cnt;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // pointer and fill update
    always_comb begin
        f_next = f_reg;
        if (push) begin
            f_next.wp = (f_reg.wp == AW'(DEPTH - 1)) ? '0 : f_reg.wp + 1'b1;
        end
        if (pop) begin
            f_next.rp = (f_reg.rp == AW'(DEPTH - 1)) ? '0 : f_reg.rp + 1'b1;
        end
        f_next.cnt = f_reg.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[f_reg.wp] <= inData;
        end
    end

    fifoBound_a: assert property (@(posedge mclk) disable iff (rst)
        f_reg.cnt <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

// Summary of operation
// - A bulk delay of 0 to 2400 samples (0 to 150 ms at 16 kHz) can go on the reference or mic path.
// - Only one stream is delayed, by the own estimate or a host value, and the pair goes on.
// - Automatic mode estimates from the start and re-estimates after every result.
// - Manual mode keeps the estimator off until the host triggers.
// - A trigger either takes one estimate or applies the fixed delay, as the host selects.
// - A manual delay holds until a new fixed delay, a new estimate or automatic mode.
// - Estimate-on-start-up is the reset mode and takes one estimate right after start.
// - After that estimate nothing changes unless triggered or automatic mode is chosen.
// - The interference canceller adapts only while no voice is reported.
// - Speech blocks gain updates of the recognition output channel.
// - Echo cancellation covers a tail of up to 225 ms.
// - Processing runs at 16 kHz and the audio interfaces select 16 or 48 kHz.
// - The automatic gain can be set over a 60 dB range.
// - Four echo path models, one per reference and mic pairing, adapt all the time.
module reference_delay_align
    import delay_align_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire pair_t sampleIn,
    input wire logic sampleValid,
    output logic sampleReady,
    output pair_t alignedOut,
    output logic alignedValid,
    input wire logic alignedReady,
    input wire logic voiceActive,
    output logic icAdapt,
    output logic asrGainHold,
    output logic [3:0] modelAdapt,
    output logic rate48,
    output logic [5:0] gainDb,
    output logic [11:0] tailSamples
);
    state_t s_reg;
    state_t s_next;
    pair_t hist [HIST_DEPTH];
    pair_t delayed;
    pair_t current;
    logic accept;
    logic doWrite;
    logic refHit;
    logic micHit;
    logic otherHit;
    logic fifoInReady;
    logic [3:0] fifoCount;
    logic [31:0] wd;
    logic [11:0] rdIdx;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] mag(input logic [15:0] x);
        mag = x[15] ? 16'(-x) : x;
    endfunction

    function automatic logic [11:0] satDelay(input logic [11:0] d);
        satDelay = (d > MAX_DELAY) ? MAX_DELAY : d;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    // ----------------------------------------
    // sample path
    // ----------------------------------------
    assign accept = sampleValid && s_reg.sampleReady;
    assign current = sampleIn;
    assign rdIdx = s_reg.wp - s_reg.applied;
    assign delayed = hist[rdIdx];
    assign refHit = mag(sampleIn.refSample) > s_reg.thresh;
    assign micHit = mag(sampleIn.micSample) > s_reg.thresh;
    assign otherHit = s_reg.estFirstMic ? refHit : micHit;
    assign doWrite = avsWrite && !s_reg.waitReq;

    // history of both streams, one word per sample
    always_ff @(posedge mclk) begin
        if (accept) begin
            hist[s_reg.wp] <= sampleIn;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        wd = '0;
        s_next.icAdapt = !voiceActive;
        s_next.asrHold = voiceActive;
        s_next.modelAdapt = ALL_MODELS;
        // room for everything that may still land in the fifo
        s_next.sampleReady = fifoCount <= FIFO_READY_MAX;
        if (s_reg.pushValid && fifoInReady) begin
            s_next.pushValid = 1'b0;
        end

        // one delayed stream, the other straight through
        if (accept) begin
            s_next.wp = s_reg.wp + 12'h001;
            s_next.pushValid = 1'b1;
            s_next.pushData = current;
            if (s_reg.applied != 12'h000) begin
                if (s_reg.onMic) begin
                    s_next.pushData.micSample = delayed.micSample;
                end else begin
                    s_next.pushData.refSample = delayed.refSample;
                end
            end
            // a pending fixed delay lands on a sample boundary
            if (s_reg.pendFix) begin
                s_next.applied = satDelay(s_reg.fixedDelay);
                s_next.onMic = s_reg.pendOnMic;
                s_next.pendFix = 1'b0;
            end
            // onset estimator: samples between the two streams crossing threshold
            case (s_reg.est)
                EST_ARM: begin
                    if (refHit && micHit) begin
                        s_next.applied = 12'h000;
                        s_next.onMic = 1'b0;
                        s_next.est = (s_reg.mode == MODE_AUTO) ? EST_ARM : EST_OFF;
                    end else if (refHit || micHit) begin
                        s_next.est = EST_COUNT;
                        s_next.estFirstMic = micHit;
                        s_next.estCount = 12'h001;
                    end
                end
                EST_COUNT: begin
                    if (otherHit || s_reg.estCount >= MAX_DELAY) begin
                        s_next.applied = satDelay(s_reg.estCount);
                        s_next.onMic = s_reg.estFirstMic;
                        s_next.est = (s_reg.mode == MODE_AUTO) ? EST_ARM : EST_OFF;
                    end else begin
                        s_next.estCount = s_reg.estCount + 12'h001;
                    end
                end
                default: begin
                end
            endcase
        end

        // bus: one wait cycle, then the access completes
        s_next.waitReq = s_reg.waitReq ? !(avsRead || avsWrite) : 1'b1;
        if (s_reg.waitReq && avsRead) begin
            if (avsAddress == OFS_CTRL) begin
                s_next.readData = {29'h0, s_reg.rate48, s_reg.mode};
            end else if (avsAddress == OFS_FIXED) begin
                s_next.readData = {20'h0, s_reg.fixedDelay};
            end else if (avsAddress == OFS_THRESH) begin
                s_next.readData = {16'h0, s_reg.thresh};
            end else if (avsAddress == OFS_GAIN) begin
                s_next.readData = {26'h0, s_reg.gain};
            end else if (avsAddress == OFS_STATUS) begin
                s_next.readData = {17'h0, s_reg.pendFix, s_reg.est != EST_OFF,
                                   s_reg.onMic, s_reg.applied};
            end else begin
                s_next.readData = 32'h0;
            end
        end

        // register writes, after the estimator so a host command wins
        if (doWrite) begin
            if (avsAddress == OFS_CTRL) begin
                wd = merge({29'h0, s_reg.rate48, s_reg.mode}, avsWriteData, avsByteEnable);
                s_next.rate48 = wd[CTRL_RATE48];
                if (wd[1:0] == MODE_AUTO) begin
                    s_next.mode = MODE_AUTO;
                    if (s_reg.est == EST_OFF) begin
                        s_next.est = EST_ARM;
                    end
                end else if (wd[1:0] == MODE_MANUAL && s_reg.mode != MODE_MANUAL) begin
                    s_next.mode = MODE_MANUAL;
                    s_next.est = EST_OFF;
                end else if (wd[1:0] == MODE_STARTUP && s_reg.mode != MODE_STARTUP) begin
                    s_next.mode = MODE_STARTUP;
                    s_next.est = EST_ARM;
                end
                if (wd[CTRL_TRIG]) begin
                    if (wd[CTRL_TRIG_FIXED]) begin
                        s_next.pendFix = 1'b1;
                        s_next.pendOnMic = wd[CTRL_FIXED_MIC];
                        s_next.est = EST_OFF;
                    end else begin
                        s_next.est = EST_ARM;
                    end
                end
            end else if (avsAddress == OFS_FIXED) begin
                wd = merge({20'h0, s_reg.fixedDelay}, avsWriteData, avsByteEnable);
                s_next.fixedDelay = satDelay(wd[11:0]);
            end else if (avsAddress == OFS_THRESH) begin
                wd = merge({16'h0, s_reg.thresh}, avsWriteData, avsByteEnable);
                s_next.thresh = wd[15:0];
            end else if (avsAddress == OFS_GAIN) begin
                wd = merge({26'h0, s_reg.gain}, avsWriteData, avsByteEnable);
                s_next.gain = (wd[7:0] > 8'(GAIN_MAX_DB)) ? GAIN_MAX_DB : wd[5:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // output buffer
    // ----------------------------------------
    pair_fifo #(
        .WIDTH($bits(pair_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .inData(s_reg.pushData),
        .inValid(s_reg.pushValid),
        .inReady(fifoInReady),
        .outData(alignedOut),
        .outValid(alignedValid),
        .outReady(alignedReady),
        .count(fifoCount)
    );

    // outputs
    assign avsReadData = s_reg.readData;
    assign avsWaitRequest = s_reg.waitReq;
    assign sampleReady = s_reg.sampleReady;
    assign icAdapt = s_reg.icAdapt;
    assign asrGainHold = s_reg.asrHold;
    assign modelAdapt = s_reg.modelAdapt;
    assign rate48 = s_reg.rate48;
    assign gainDb = s_reg.gain;
    assign tailSamples = TAIL_SAMPLES;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence busReq;
        (avsRead || avsWrite) && avsWaitRequest;
    endsequence

    sequence busAck;
        ##1 !avsWaitRequest ##1 avsWaitRequest;
    endsequence

    busAnswer_a: assert property (@(posedge mclk) disable iff (rst)
        busReq |-> busAck) else $error("bus answer not one cycle after request");

    delaySat_a: assert property (@(posedge mclk) disable iff (rst)
        s_reg.applied <= MAX_DELAY && s_reg.fixedDelay <= MAX_DELAY)
        else $error("delay above limit");

    micStraight_a: assert property (@(posedge mclk) disable iff (rst)
        accept && !s_reg.onMic |=> s_reg.pushData.micSample == $past(sampleIn.micSample))
        else $error("mic delayed while reference path selected");

    autoRearm_a: assert property (@(posedge mclk) disable iff (rst)
        s_reg.mode == MODE_AUTO && s_reg.est == EST_COUNT && accept && otherHit && !doWrite
        |=> s_reg.est == EST_ARM) else $error("auto mode did not re-arm");

    manualIdle_a: assert property (@(posedge mclk) disable iff (rst)
        s_reg.mode == MODE_MANUAL && s_reg.est == EST_OFF && !doWrite
        |=> s_reg.est == EST_OFF) else $error("estimator started without trigger");

    manualHold_a: assert property (@(posedge mclk) disable iff (rst)
        s_reg.est == EST_OFF && !s_reg.pendFix && !doWrite |=> $stable(s_reg.applied))
        else $error("delay changed without cause");

    startupArm_a: assert property (@(posedge mclk)
        $fell(rst) |-> s_reg.mode == MODE_STARTUP && s_reg.est == EST_ARM)
        else $error("not estimating after reset");

    voiceGate_a: assert property (@(posedge mclk) disable iff (rst)
        !rst |=> icAdapt == !$past(voiceActive) && asrGainHold == $past(voiceActive))
        else $error("adaptation gating wrong");

    gainRange_a: assert property (@(posedge mclk) disable iff (rst)
        gainDb <= GAIN_MAX_DB) else $error("gain above range");
endmodule

// ### inc/delay_align_pkg.sv
package delay_align_pkg;

    // ----------------------------------------
    // rates and limits
    // ----------------------------------------
    localparam int SAMPLE_RATE_HZ = 16000;
    localparam int MAX_DELAY_MS = 150;
    localparam logic [11:0] MAX_DELAY = 12'(MAX_DELAY_MS * SAMPLE_RATE_HZ / 1000);
    localparam int TAIL_MS = 225;
    localparam logic [11:0] TAIL_SAMPLES = 12'(TAIL_MS * SAMPLE_RATE_HZ / 1000);
    localparam logic [5:0] GAIN_MAX_DB = 6'h3C;
    localparam int HIST_DEPTH = 4096;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_READY_MAX = 4'h5;
    localparam logic [3:0] ALL_MODELS = 4'hF;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FIXED = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_GAIN = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam int CTRL_RATE48 = 2;
    localparam int CTRL_TRIG = 8;
    localparam int CTRL_TRIG_FIXED = 9;
    localparam int CTRL_FIXED_MIC = 10;
    localparam logic [15:0] THRESH_RST = 16'h0400;
    localparam logic [5:0] GAIN_RST = 6'h00;

    // ----------------------------------------
    // types
    // ----------------------------------------
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_STARTUP = 2'h2;

    typedef enum logic [1:0] {EST_OFF, EST_ARM, EST_COUNT} est_t;

    typedef struct packed {
        logic [15:0] refSample;
        logic [15:0] micSample;
    } pair_t;

    typedef struct packed {
        logic [1:0] mode;
        logic rate48;
        logic [11:0] fixedDelay;
        logic [15:0] thresh;
        logic [5:0] gain;
        logic [11:0] applied;
        logic onMic;
        logic pendFix;
        logic pendOnMic;
        est_t est;
        logic estFirstMic;
        logic [11:0] estCount;
        logic [11:0] wp;
        logic pushValid;
        pair_t pushData;
        logic sampleReady;
        logic waitReq;
        logic [31:0] readData;
        logic icAdapt;
        logic asrHold;
        logic [3:0] modelAdapt;
    } state_t;

    localparam state_t STATE_RST = '{mode: MODE_STARTUP, est: EST_ARM, waitReq: 1'b1,
        thresh: THRESH_RST, gain: GAIN_RST, default: '0};

endpackage

// ### verif/host_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// host processor on the register bus
// ----------------------------------------
module host_model
    import delay_align_pkg::*;
(
    input wire logic mclk,
    output logic [7:0] avsAddress,
    output logic avsRead,
    output logic avsWrite,
    output logic [31:0] avsWriteData,
    output logic [3:0] avsByteEnable,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest
);
    // idle bus from time zero
    initial begin
        avsAddress = 8'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWriteData = 32'h00000000;
        avsByteEnable = 4'hF;
    end

    // one access, held until waitrequest is seen low at a rising edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge mclk); while (avsWaitRequest !== 1'b0);
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        avsWriteData <= ~d; // stale data is not left on the lines
        @(posedge mclk);
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [31:0] q);
        access(1'b0, a, 32'h00000000, q);
    endtask

    // trigger names the kind of delay wanted: fixed value or one estimate
    task automatic trigger(input logic [1:0] mode, input logic fix, input logic mic);
        write_reg(OFS_CTRL, {21'h0, mic, fix, 1'b1, 5'h00, 1'b0, mode});
    endtask
endmodule

// ### verif/reference_delay_align_bench.sv
`timescale 1ns/100ps

module reference_delay_align_bench
    import delay_align_pkg::*;
;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avsAddress;
    logic avsRead, avsWrite, avsWaitRequest, rate48, icAdapt, asrGainHold;
    logic [31:0] avsWriteData, avsReadData, rd;
    logic [3:0] avsByteEnable, modelAdapt;
    pair_t sampleIn = '0, alignedOut;
    logic sampleValid = 1'b0, alignedReady = 1'b1, voiceActive = 1'b0;
    logic sampleReady, alignedValid;
    logic [5:0] gainDb;
    logic [11:0] tailSamples;
    int miscompares = 0, nTests = 0, acc;
    pair_t got[$];

    host_model i_host (.mclk(mclk), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));

    reference_delay_align i_dut (.mclk(mclk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .sampleIn(sampleIn), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .alignedOut(alignedOut), .alignedValid(alignedValid),
        .alignedReady(alignedReady), .voiceActive(voiceActive), .icAdapt(icAdapt),
        .asrGainHold(asrGainHold), .modelAdapt(modelAdapt), .rate48(rate48),
        .gainDb(gainDb), .tailSamples(tailSamples));

    // 50 MHz clock
    always #10 mclk = ~mclk;

    // collect every pair popped at the output
    always @(posedge mclk) begin
        if (alignedValid === 1'b1 && alignedReady === 1'b1) got.push_back(alignedOut);
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        nTests++;
        if (g !== e) begin
            $display("ERROR time=%0t got=%h expected=%h", $time, g, e);
            miscompares++;
        end
    endtask

    task automatic status_is(input logic [31:0] e);
        i_host.read_reg(OFS_STATUS, rd);
        check(rd & 32'h00001FFF, e);
    endtask

    // one pair, held until taken; valid stays up for the next call
    task automatic push(input logic [15:0] r, input logic [15:0] m);
        sampleValid <= 1'b1;
        sampleIn <= '{refSample: r, micSample: m};
        do @(posedge mclk); while (sampleReady !== 1'b1);
    endtask

    task automatic idle();
        sampleValid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // single loud sample on each stream, d samples apart
    task automatic onset(input int d, input logic micFirst);
        logic a, b;
        repeat (3) push(16'h0000, 16'h0000);
        for (int i = 0; i <= d; i++) begin
            a = (i == 0);
            b = (i == d);
            push((micFirst ? b : a) ? 16'h2000 : 16'h0000,
                 (micFirst ? a : b) ? 16'h2000 : 16'h0000);
        end
        repeat (4) push(16'h0000, 16'h0000);
        idle();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(32'(modelAdapt), 32'h0000000F);
        check(32'(tailSamples), 32'h00000E10);
        i_host.read_reg(OFS_THRESH, rd);
        check(rd, 32'h00000400);
        i_host.read_reg(8'h14, rd);
        check(rd, 32'h00000000);
        i_host.write_reg(OFS_GAIN, 32'h0000003F);
        i_host.read_reg(OFS_GAIN, rd);
        check(rd, 32'h0000003C);
        check(32'(gainDb), 32'h0000003C);
        i_host.write_reg(OFS_CTRL, 32'h00000006);
        check(32'(rate48), 32'h00000001);
        i_host.write_reg(OFS_CTRL, 32'h00000002);
        check(32'(rate48), 32'h00000000);
        $display("test done: registers");
    endtask

    task automatic t_voice();
        voiceActive <= 1'b1;
        repeat (3) @(posedge mclk);
        check(32'(icAdapt), 32'h00000000);
        check(32'(asrGainHold), 32'h00000001);
        voiceActive <= 1'b0;
        repeat (3) @(posedge mclk);
        check(32'(icAdapt), 32'h00000001);
        check(32'(asrGainHold), 32'h00000000);
        $display("test done: voice gating");
    endtask

    task automatic t_startup();
        onset(5, 1'b0);
        status_is(32'h00000005);
        onset(9, 1'b1);
        status_is(32'h00000005);
        $display("test done: start-up estimate");
    endtask

    task automatic t_auto();
        i_host.write_reg(OFS_CTRL, 32'h00000000);
        onset(7, 1'b0);
        status_is(32'h00000007);
        onset(2, 1'b1);
        status_is(32'h00001002);
        $display("test done: automatic");
    endtask

    task automatic t_manual();
        i_host.write_reg(OFS_CTRL, 32'h00000001);
        onset(6, 1'b0);
        status_is(32'h00001002);
        i_host.write_reg(OFS_FIXED, 32'h00000BB8);
        i_host.read_reg(OFS_FIXED, rd);
        check(rd, 32'h00000960);
        i_host.write_reg(OFS_FIXED, 32'h00000003);
        i_host.trigger(MODE_MANUAL, 1'b1, 1'b1);
        push(16'h0000, 16'h0000);
        idle();
        status_is(32'h00001003);
        got.delete();
        for (int k = 0; k < 10; k++) push(16'(k), 16'(32'h100 + k));
        idle();
        repeat (50) if (got.size() < 10) @(posedge mclk);
        check(32'(got.size()), 32'h0000000A);
        for (int k = 3; k < 10 && k < got.size(); k++)
            check(got[k], {16'(k), 16'(32'h100 + k - 3)});
        i_host.trigger(MODE_MANUAL, 1'b0, 1'b0);
        onset(4, 1'b1);
        status_is(32'h00001004);
        $display("test done: manual");
    endtask

    task automatic t_fifo();
        alignedReady <= 1'b0;
        sampleValid <= 1'b1;
        sampleIn <= 32'h00010001;
        acc = 0;
        repeat (12) begin
            @(posedge mclk);
            if (sampleReady === 1'b1) acc++;
        end
        sampleValid <= 1'b0;
        repeat (2) @(posedge mclk);
        check(32'(sampleReady), 32'h00000000);
        check(32'(alignedValid), 32'h00000001);
        check(32'(acc <= FIFO_DEPTH && acc > 0), 32'h00000001);
        got.delete();
        alignedReady <= 1'b1;
        repeat (50) if (got.size() < acc) @(posedge mclk);
        repeat (2) @(posedge mclk);
        check(32'(got.size()), 32'(acc));
        check(32'(alignedValid), 32'h00000000);
        $display("test done: buffer");
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        // outputs first load at the edge after release, so look one edge later
        repeat (2) @(posedge mclk);
        t_reset();
        t_voice();
        t_startup();
        t_auto();
        t_manual();
        t_fifo();
        final_report();
    end
endmodule
